// ### rtl/mdsb_regs.svh
// Overview of operation
// [R01] Brake output stays off while bus voltage is below the lower threshold.
// [R02] Between thresholds, brake duty rises linearly from 0% to 100%.
// [R03] Brake output stays fully on above the upper threshold.
// [R04] A started service runs to its end; pending services wait.
// [R05] Tasks without real outputs drive a debug pin high while serving.
// [R06] Speed measurement, ramp and controller run every 20th pwm period.
// [R07] Current loop runs every period as three consecutive threads.
// [R08] Sensing output rises first in the period and starts the converter.
// [R09] Second sensing edge preprocesses currents and bus voltage samples.
// [R10] First sensing thread links to the speed task every 20th period.
// [R11] Speed task then requests brake update, both before second sensing edge.
// [R12] Second sensing thread requests the current loop every period.
// [R13] After third current thread, the pwm master takes the new vector.
// [R14] Pwm master update is deferred a period if the chain is unfinished.
// [R15] Pwm master update starts a set update time before period end.
// [R16] Real quantities are 24-bit signed fractions of their full range.
// [R17] Default format is 1.23; 0x800000 is -1.0, 0x7FFFFF most positive.
// [R18] Voltage vector to the pwm master uses 3.21 format.
// [R19] Speed is position change over edge-time change times a scaling factor.
// [R20] Speed task clears the position difference after reading it.
// [R21] Scaling factor is 30*256*timer rate over speed range times counts.
// [R22] Speed loop runs a controller on measured speed and ramped target.
// [R23] Current loop optionally limits d and q voltage to a circle; the code halves both once when they lie outside it.
// [R24] First sensing edge is aligned with the start of the pwm period.
// [R25] Brake pwm runs at 10 kHz, taking new duty every second period.
// [R26] Speed results beyond 1.23 range saturate instead of wrapping.
// [R27] Brake duty is excess over lower threshold divided by span, clamped.
`ifndef MDSB_REGS_SVH
`define MDSB_REGS_SVH
`define MDSB_CLK_HZ      200000000
`define MDSB_PWM_HZ      20000
`define MDSB_BRAKE_HZ    10000
`define MDSB_SPEED_DIV   20
`define MDSB_FRAC_MIN    24'h800000
`define MDSB_FRAC_MAX    24'h7FFFFF
`define MDSB_DUTY_FULL   24'h800000
`define MDSB_DIV_STEPS   6'h30
`define MDSB_ADR_CTRL    8'h00
`define MDSB_ADR_LOWER   8'h04
`define MDSB_ADR_UPPER   8'h08
`define MDSB_ADR_TARGET  8'h0C
`define MDSB_ADR_SCALE   8'h10
`define MDSB_ADR_UPDTIME 8'h14
`define MDSB_ADR_KP      8'h18
`define MDSB_ADR_KI      8'h1C
`define MDSB_ADR_RAMP    8'h20
`define MDSB_ADR_CLIM    8'h24
`define MDSB_ADR_IDREF   8'h28
`define MDSB_ADR_SPEED   8'h2C
`define MDSB_ADR_DUTY    8'h30
`define MDSB_ADR_STATUS  8'h34
`define MDSB_CTRL_CLOSED 0
`define MDSB_CTRL_CIRCLE 1
`define MDSB_RST_LOWER   24'h600000
`define MDSB_RST_UPPER   24'h700000
`define MDSB_RST_UPDTIME 16'h0400
`endif

// ### rtl/mdsb_pkg.sv
`default_nettype none
package mdsb_pkg;
   typedef enum logic [3:0] {
      MDSB_IDLE = 4'h0, MDSB_SENSE1 = 4'h1, MDSB_SPD_DIV = 4'h2, MDSB_SPD_PID = 4'h3,
      MDSB_BRK_CHK = 4'h4, MDSB_BRK_DIV = 4'h5, MDSB_BRK_SET = 4'h6, MDSB_SENSE2 = 4'h7,
      MDSB_CL1 = 4'h8, MDSB_CL2 = 4'h9, MDSB_CL3 = 4'hA, MDSB_REQ = 4'hB, MDSB_MASTER = 4'hC
   } mdsb_fsm_type;
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } mdsb_bus_type;
   typedef struct packed {
      logic [23:0] ia;
      logic [23:0] ib;
      logic [23:0] ubus;
   } mdsb_sample_type;
   typedef struct packed {
      logic speed;
      logic brake;
      logic current;
      logic master;
   } mdsb_dbg_type;
   typedef struct packed {
      logic [23:0] alpha;
      logic [23:0] beta;
   } mdsb_vec_type;
   typedef struct packed {
      logic [1:0]   ctrl;
      logic [23:0]  lower, upper, target, scale, kp, ki, ramp, clim, idref;
      logic [15:0]  updtime;
      mdsb_fsm_type fsm;
      logic [2:0]   rdy_sync, inc_sync, dec_sync;
      logic [15:0]  per_cnt;
      logic         per_par;
      logic [4:0]   per_idx;
      logic         ev_s1, ev_s2, ev_m;
      logic [23:0]  tbase, delta, last_edge, prev_edge;
      logic         dneg;
      logic [47:0]  div_num;
      logic [23:0]  div_den;
      logic [24:0]  div_rem;
      logic [5:0]   div_cnt;
      logic [23:0]  omega, req, integ, torque, u_f, ia, ib, duty, ed, eq, va, vb;
      logic [16:0]  hi_cnt, act_hi;
      logic         cl_done, circ_flag, pwm_upd, adc_start, brake_out;
      logic [7:0]   defer_cnt;
      mdsb_vec_type pwm_vec;
      mdsb_dbg_type dbg;
      logic [31:0]  rdata;
   } mdsb_state_type;
endpackage
`default_nettype wire

// ### rtl/mdsb_core.sv
// Design decisions made here: the plain strobed port and the address map.
`include "mdsb_regs.svh"
`default_nettype none
module mdsb_core
   import mdsb_pkg::*;
#(
   parameter int unsigned PWM_CYC   = `MDSB_CLK_HZ / `MDSB_PWM_HZ, // cycles per pwm period
   parameter int unsigned SPEED_DIV = `MDSB_SPEED_DIV             // periods per speed step
)(
   input  wire logic            ref_clk,       // 200 MHz clock
   input  wire logic            sys_rst,       // async reset, active high
   input  wire mdsb_bus_type    bus,           // register request
   output logic [31:0]          bus_rdata,     // read data, cycle after strobe
   input  wire logic            adc_ready_pin, // samples stored, rising edge
   input  wire mdsb_sample_type sample,        // currents and bus voltage
   input  wire logic            enc_inc_pin,   // encoder count up edge
   input  wire logic            enc_dec_pin,   // encoder count down edge
   output logic                 adc_start,     // sensing output, starts converter
   output logic                 brake_out,     // bus brake control
   output mdsb_dbg_type         dbg,           // activity pins
   output mdsb_vec_type         pwm_vec,       // applied vector, 3.21
   output logic                 pwm_update     // vector updated pulse
);
   localparam int unsigned BRAKE_CYC = 2 * PWM_CYC; // brake period is two pwm periods

   mdsb_state_type st_ff;
   mdsb_state_type nxt;

   // saturate a magnitude with sign into 1.23
   function automatic logic [23:0] sat_mag(input logic [47:0] q, input logic neg);
      logic [23:0] r;
      r = 24'h000000;
      if (neg) begin
         r = (q >= 48'h000000800000) ? `MDSB_FRAC_MIN : 24'(-q[23:0]);
      end else begin
         r = (q > 48'h0000007FFFFF) ? `MDSB_FRAC_MAX : q[23:0];
      end
      return r;
   endfunction

   // saturate a wide signed sum into 1.23
   function automatic logic [23:0] sat24(input logic signed [49:0] x);
      logic [23:0] r;
      r = x[23:0];
      if (x > 50'sh00000007FFFFF) begin
         r = `MDSB_FRAC_MAX;
      end else if (x < -50'sh0000000800000) begin
         r = `MDSB_FRAC_MIN;
      end
      return r;
   endfunction

   logic               per_start;
   logic               per_end;
   logic               window;
   logic               rdy_edge;
   logic signed [23:0] enc_step;
   logic [24:0]        div_try;
   logic [47:0]        quot;
   logic signed [49:0] diff;
   logic signed [49:0] err;
   logic signed [49:0] pterm;
   logic signed [49:0] iterm;
   logic [23:0]        req_new;
   logic [23:0]        integ_new;
   logic [48:0]        mag2;
   logic [47:0]        lim2;
   logic [16:0]        brk_pos;
   logic [40:0]        hi_prod;

   always_comb begin
      nxt         = st_ff;
      nxt.pwm_upd = 1'b0;
      // pin synchronisers, third stage only for edge detection
      nxt.rdy_sync = {st_ff.rdy_sync[1:0], adc_ready_pin};
      nxt.inc_sync = {st_ff.inc_sync[1:0], enc_inc_pin};
      nxt.dec_sync = {st_ff.dec_sync[1:0], enc_dec_pin};
      rdy_edge     = st_ff.rdy_sync[1] & ~st_ff.rdy_sync[2];
      enc_step     = 24'sh000000;
      if (st_ff.inc_sync[1] & ~st_ff.inc_sync[2] & ~(st_ff.dec_sync[1] & ~st_ff.dec_sync[2])) begin
         enc_step = 24'sh000001;
      end else if (st_ff.dec_sync[1] & ~st_ff.dec_sync[2]
                   & ~(st_ff.inc_sync[1] & ~st_ff.inc_sync[2])) begin
         enc_step = -24'sh000001;
      end
      // encoder accumulation and last-transition time
      nxt.tbase = st_ff.tbase + 24'h000001;
      nxt.delta = st_ff.delta + enc_step;
      if (enc_step != 24'sh000000) begin
         nxt.last_edge = st_ff.tbase;
      end
      // pwm period frame and speed divider
      per_start = (st_ff.per_cnt == 16'h0000);
      per_end   = (st_ff.per_cnt == 16'(PWM_CYC - 1));
      window    = (st_ff.per_cnt == 16'(PWM_CYC - 32'(st_ff.updtime))); // R15
      nxt.per_cnt = per_end ? 16'h0000 : st_ff.per_cnt + 16'h0001;
      if (per_end) begin
         nxt.per_par = ~st_ff.per_par;
         nxt.per_idx = (st_ff.per_idx == 5'(SPEED_DIV - 1)) ? 5'h00 : st_ff.per_idx + 5'h01;
      end
      // brake pwm over two motor periods, duty taken at its start
      brk_pos = st_ff.per_par ? 17'(st_ff.per_cnt) + 17'(PWM_CYC) : 17'(st_ff.per_cnt);
      if (per_start && !st_ff.per_par) begin
         nxt.act_hi = st_ff.hi_cnt; // R25
      end
      nxt.brake_out = (brk_pos < st_ff.act_hi); // R01 R02 R03
      // event flags, a new set wins over the clear of a taken one
      nxt.ev_s1 = st_ff.ev_s1 | per_start; // R24
      nxt.ev_s2 = st_ff.ev_s2 | rdy_edge;
      nxt.ev_m  = st_ff.ev_m | (window & st_ff.cl_done);
      if (window && !st_ff.cl_done) begin
         nxt.defer_cnt = st_ff.defer_cnt + 8'h01; // R14
      end
      // shared restoring divider
      div_try = {st_ff.div_rem[23:0], st_ff.div_num[47]};
      quot    = st_ff.div_num;
      if (st_ff.fsm == MDSB_SPD_DIV || st_ff.fsm == MDSB_BRK_DIV) begin
         nxt.div_cnt = st_ff.div_cnt - 6'h01;
         if (div_try >= {1'b0, st_ff.div_den}) begin
            nxt.div_rem = div_try - {1'b0, st_ff.div_den};
            nxt.div_num = {st_ff.div_num[46:0], 1'b1};
         end else begin
            nxt.div_rem = div_try;
            nxt.div_num = {st_ff.div_num[46:0], 1'b0};
         end
         quot = nxt.div_num;
      end
      // ramp and pi arithmetic
      diff = 50'(signed'(st_ff.target)) - 50'(signed'(st_ff.req));
      req_new = st_ff.target;
      if (diff > 50'(signed'({1'b0, st_ff.ramp}))) begin
         req_new = st_ff.req + st_ff.ramp;
      end else if (diff < -50'(signed'({1'b0, st_ff.ramp}))) begin
         req_new = st_ff.req - st_ff.ramp;
      end
      err       = 50'(signed'(sat24(50'(signed'(req_new)) - 50'(signed'(st_ff.omega)))));
      pterm     = (err * 50'(signed'(st_ff.kp))) >>> 23;
      iterm     = (err * 50'(signed'(st_ff.ki))) >>> 23;
      integ_new = sat24(50'(signed'(st_ff.integ)) + iterm);
      mag2      = 49'(signed'(st_ff.ed) * signed'(st_ff.ed))
                  + 49'(signed'(st_ff.eq) * signed'(st_ff.eq));
      lim2      = st_ff.clim * st_ff.clim;
      hi_prod   = st_ff.duty * 17'(BRAKE_CYC);
      // service engine, one service at a time to its end
      unique case (st_ff.fsm)
         MDSB_IDLE: begin // R04
            if (st_ff.ev_m) begin
               nxt.ev_m = window & st_ff.cl_done;
               nxt.fsm  = MDSB_MASTER;
            end else if (st_ff.ev_s1) begin
               nxt.ev_s1 = per_start;
               nxt.fsm   = MDSB_SENSE1;
            end else if (st_ff.ev_s2) begin
               nxt.ev_s2 = rdy_edge;
               nxt.fsm   = MDSB_SENSE2;
            end
         end
         MDSB_SENSE1: begin
            nxt.adc_start = 1'b1; // R08
            nxt.fsm       = MDSB_IDLE;
            if (st_ff.per_idx == 5'h00) begin // R06 R10
               nxt.delta     = enc_step; // R20
               nxt.dneg      = st_ff.delta[23];
               nxt.div_num   = 48'(st_ff.delta[23] ? 24'(-st_ff.delta) : st_ff.delta)
                               * 48'(st_ff.scale); // R19 R21
               nxt.div_den   = st_ff.last_edge - st_ff.prev_edge;
               nxt.prev_edge = st_ff.last_edge;
               nxt.div_rem   = 25'h0000000;
               nxt.div_cnt   = `MDSB_DIV_STEPS;
               nxt.fsm       = MDSB_SPD_DIV;
            end
         end
         MDSB_SPD_DIV: begin
            if (st_ff.div_cnt == 6'h01) begin
               nxt.omega = sat_mag(quot, st_ff.dneg); // R26
               nxt.fsm   = MDSB_SPD_PID;
            end
         end
         MDSB_SPD_PID: begin // R22
            nxt.req    = req_new;
            nxt.integ  = integ_new;
            nxt.torque = st_ff.ctrl[`MDSB_CTRL_CLOSED]
                         ? sat24(pterm + 50'(signed'(integ_new))) : req_new;
            nxt.fsm    = MDSB_BRK_CHK; // R11
         end
         MDSB_BRK_CHK: begin
            nxt.fsm = MDSB_BRK_SET;
            if (signed'(st_ff.u_f) <= signed'(st_ff.lower)) begin
               nxt.duty = 24'h000000; // R01
            end else if (signed'(st_ff.u_f) >= signed'(st_ff.upper)) begin
               nxt.duty = `MDSB_DUTY_FULL; // R03
            end else begin
               nxt.div_num = {1'b0, 24'(st_ff.u_f - st_ff.lower), 23'h000000}; // R27
               nxt.div_den = st_ff.upper - st_ff.lower;
               nxt.div_rem = 25'h0000000;
               nxt.div_cnt = `MDSB_DIV_STEPS;
               nxt.fsm     = MDSB_BRK_DIV;
            end
         end
         MDSB_BRK_DIV: begin
            if (st_ff.div_cnt == 6'h01) begin
               nxt.duty = (quot > 48'(`MDSB_DUTY_FULL)) ? `MDSB_DUTY_FULL : quot[23:0]; // R02 R27
               nxt.fsm  = MDSB_BRK_SET;
            end
         end
         MDSB_BRK_SET: begin
            nxt.hi_cnt = hi_prod[39:23];
            nxt.fsm    = MDSB_IDLE;
         end
         MDSB_SENSE2: begin // R09
            nxt.adc_start = 1'b0;
            nxt.ia        = sample.ia;
            nxt.ib        = sample.ib;
            nxt.u_f       = sat24(50'(signed'(st_ff.u_f))
                            + ((50'(signed'(sample.ubus)) - 50'(signed'(st_ff.u_f))) >>> 2));
            nxt.fsm       = MDSB_CL1; // R12
         end
         MDSB_CL1: begin // R07
            nxt.ed  = sat24(50'(signed'(st_ff.idref)) - 50'(signed'(st_ff.ia)));
            nxt.eq  = sat24(50'(signed'(st_ff.torque)) - 50'(signed'(st_ff.ib)));
            nxt.fsm = MDSB_CL2;
         end
         MDSB_CL2: begin
            nxt.circ_flag = 1'b0;
            if (st_ff.ctrl[`MDSB_CTRL_CIRCLE] && mag2 > {1'b0, lim2}) begin // R23
               nxt.ed        = 24'(signed'(st_ff.ed) >>> 1);
               nxt.eq        = 24'(signed'(st_ff.eq) >>> 1);
               nxt.circ_flag = 1'b1;
            end
            nxt.fsm = MDSB_CL3;
         end
         MDSB_CL3: begin
            nxt.va      = 24'(signed'(st_ff.ed) >>> 2); // R18 R16 R17
            nxt.vb      = 24'(signed'(st_ff.eq) >>> 2);
            nxt.fsm     = MDSB_REQ; // R13
         end
         MDSB_REQ: begin
            nxt.cl_done = 1'b1;
            nxt.fsm     = MDSB_IDLE;
         end
         MDSB_MASTER: begin
            nxt.pwm_vec = '{alpha: st_ff.va, beta: st_ff.vb};
            nxt.pwm_upd = 1'b1;
            nxt.cl_done = 1'b0;
            nxt.fsm     = MDSB_IDLE;
         end
         default: begin
            nxt.fsm = MDSB_IDLE;
         end
      endcase
      // activity pins follow the service now running
      nxt.dbg.speed   = (nxt.fsm == MDSB_SPD_DIV) || (nxt.fsm == MDSB_SPD_PID); // R05
      nxt.dbg.brake   = (nxt.fsm == MDSB_BRK_CHK) || (nxt.fsm == MDSB_BRK_DIV)
                        || (nxt.fsm == MDSB_BRK_SET);
      nxt.dbg.current = (nxt.fsm == MDSB_CL1) || (nxt.fsm == MDSB_CL2) || (nxt.fsm == MDSB_CL3);
      nxt.dbg.master  = (nxt.fsm == MDSB_REQ) || (nxt.fsm == MDSB_MASTER);
      // register writes
      if (bus.wr) begin
         unique case (bus.addr)
            `MDSB_ADR_CTRL:    nxt.ctrl    = bus.wdata[1:0];
            `MDSB_ADR_LOWER:   nxt.lower   = bus.wdata[23:0];
            `MDSB_ADR_UPPER:   nxt.upper   = bus.wdata[23:0];
            `MDSB_ADR_TARGET:  nxt.target  = bus.wdata[23:0];
            `MDSB_ADR_SCALE:   nxt.scale   = bus.wdata[23:0];
            `MDSB_ADR_UPDTIME: nxt.updtime = bus.wdata[15:0];
            `MDSB_ADR_KP:      nxt.kp      = bus.wdata[23:0];
            `MDSB_ADR_KI:      nxt.ki      = bus.wdata[23:0];
            `MDSB_ADR_RAMP:    nxt.ramp    = bus.wdata[23:0];
            `MDSB_ADR_CLIM:    nxt.clim    = bus.wdata[23:0];
            `MDSB_ADR_IDREF:   nxt.idref   = bus.wdata[23:0];
            default: ;
         endcase
      end
      // register reads, unmapped answer zero
      nxt.rdata = 32'h00000000;
      if (bus.rd) begin
         unique case (bus.addr)
            `MDSB_ADR_CTRL:    nxt.rdata = {30'h00000000, st_ff.ctrl};
            `MDSB_ADR_LOWER:   nxt.rdata = {8'h00, st_ff.lower};
            `MDSB_ADR_UPPER:   nxt.rdata = {8'h00, st_ff.upper};
            `MDSB_ADR_TARGET:  nxt.rdata = {8'h00, st_ff.target};
            `MDSB_ADR_SCALE:   nxt.rdata = {8'h00, st_ff.scale};
            `MDSB_ADR_UPDTIME: nxt.rdata = {16'h0000, st_ff.updtime};
            `MDSB_ADR_KP:      nxt.rdata = {8'h00, st_ff.kp};
            `MDSB_ADR_KI:      nxt.rdata = {8'h00, st_ff.ki};
            `MDSB_ADR_RAMP:    nxt.rdata = {8'h00, st_ff.ramp};
            `MDSB_ADR_CLIM:    nxt.rdata = {8'h00, st_ff.clim};
            `MDSB_ADR_IDREF:   nxt.rdata = {8'h00, st_ff.idref};
            `MDSB_ADR_SPEED:   nxt.rdata = {8'h00, st_ff.omega};
            `MDSB_ADR_DUTY:    nxt.rdata = {8'h00, st_ff.duty};
            `MDSB_ADR_STATUS:  nxt.rdata = {16'h0000, st_ff.defer_cnt, 2'h0,
                                            st_ff.circ_flag, st_ff.cl_done, st_ff.fsm};
            default: ;
         endcase
      end
   end

   // state register
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_ff         <= '0;
         st_ff.lower   <= `MDSB_RST_LOWER;
         st_ff.upper   <= `MDSB_RST_UPPER;
         st_ff.updtime <= `MDSB_RST_UPDTIME;
      end else begin
         st_ff <= nxt;
      end
   end

   // outputs straight from the state register
   assign bus_rdata  = st_ff.rdata;
   assign adc_start  = st_ff.adc_start;
   assign brake_out  = st_ff.brake_out;
   assign dbg        = st_ff.dbg;
   assign pwm_vec    = st_ff.pwm_vec;
   assign pwm_update = st_ff.pwm_upd;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   a_brake_zero_off: assert property (st_ff.act_hi == 17'h00000 |=> !brake_out) // R01
      else $error("brake on with zero duty");
   a_brake_full_on: assert property (st_ff.act_hi == 17'(BRAKE_CYC) |=> brake_out) // R03
      else $error("brake off with full duty");
   a_brake_low_zero: assert property ((st_ff.fsm == MDSB_BRK_CHK) // R01
      && (signed'(st_ff.u_f) <= signed'(st_ff.lower)) |=> st_ff.duty == 24'h000000)
      else $error("duty not zero below lower threshold");
   a_duty_clamped: assert property (st_ff.duty <= `MDSB_DUTY_FULL) // R27
      else $error("duty above full scale");
   a_thread_order: assert property (st_ff.fsm == MDSB_CL1 |=> st_ff.fsm == MDSB_CL2 // R07
      ##1 st_ff.fsm == MDSB_CL3 ##1 st_ff.fsm == MDSB_REQ)
      else $error("current threads out of order");
   a_no_preempt: assert property ((st_ff.fsm == MDSB_SPD_DIV) // R04
      && (st_ff.ev_s1 | st_ff.ev_s2 | st_ff.ev_m)
      |=> st_ff.fsm inside {MDSB_SPD_DIV, MDSB_SPD_PID})
      else $error("speed service preempted");
   a_dbg_current: assert property (dbg.current == (st_ff.fsm inside // R05
      {MDSB_CL1, MDSB_CL2, MDSB_CL3}))
      else $error("current debug pin wrong");
   a_speed_period: assert property ($rose(dbg.speed) |-> st_ff.per_idx == 5'h00 // R06
      && $past(st_ff.fsm) == MDSB_SENSE1)
      else $error("speed task outside its period");
   a_sense_rise: assert property ($rose(adc_start) |-> $past(st_ff.fsm) == MDSB_SENSE1) // R08
      else $error("converter start without sensing service");
   a_delta_clear: assert property ((st_ff.fsm == MDSB_SENSE1) && (st_ff.per_idx == 5'h00) // R20
      |=> st_ff.delta == $past(enc_step))
      else $error("position difference not cleared");
   a_defer_update: assert property (window && !st_ff.cl_done && !st_ff.ev_m // R14
      |=> !st_ff.ev_m)
      else $error("unfinished chain updated the vector");
   // links between services
   a_speed_link: assert property ((st_ff.fsm == MDSB_SENSE1) && (st_ff.per_idx == 5'h00) // R10
      |=> st_ff.fsm == MDSB_SPD_DIV)
      else $error("speed task not linked");
   a_brake_link: assert property (st_ff.fsm == MDSB_SPD_PID // R11
      |=> st_ff.fsm == MDSB_BRK_CHK)
      else $error("brake update not requested");
   a_current_link: assert property (st_ff.fsm == MDSB_SENSE2 // R12
      |=> (st_ff.fsm == MDSB_CL1) && !adc_start)
      else $error("current loop not requested");
   a_master_done: assert property (st_ff.fsm == MDSB_MASTER |-> st_ff.cl_done) // R13
      else $error("vector update without finished chain");
   a_period_sense: assert property (per_start |=> st_ff.ev_s1) // R24
      else $error("period start did not request sensing");
   a_speed_sat: assert property ((st_ff.fsm == MDSB_SPD_DIV) && (st_ff.div_cnt == 6'h01) // R26
      && !st_ff.dneg && (quot > 48'h0000007FFFFF) |=> st_ff.omega == `MDSB_FRAC_MAX)
      else $error("speed not saturated");

   c_speed_run: cover property (st_ff.fsm == MDSB_SPD_PID ##1 st_ff.fsm == MDSB_BRK_CHK);
   c_brake_div: cover property (st_ff.fsm == MDSB_BRK_DIV ##[1:60] st_ff.fsm == MDSB_BRK_SET);
   c_vector_upd: cover property (pwm_update);
   c_deferred: cover property (window && !st_ff.cl_done);
endmodule // mdsb_core
`default_nettype wire

// ### sim/mdsb_partner.sv
`default_nettype none
module mdsb_partner
   import mdsb_pkg::*;
(
   input  wire logic        ref_clk,       // drive clock
   input  wire logic        adc_start,     // conversion trigger
   input  wire logic [15:0] delay,         // conversion time
   input  wire logic [23:0] ubus,          // bus voltage
   output var  logic        adc_ready_pin, // samples stored
   output var  mdsb_sample_type sample,    // converted values
   output var  logic        enc_inc_pin,   // encoder up edges
   output var  logic        enc_dec_pin    // encoder down edges
);
   logic        prev = 1'b0;
   logic [15:0] cnt  = 16'h0;
   logic [15:0] dl   = 16'h0;
   logic [5:0]  enc  = 6'h0;
   // fixed currents, forward encoder, ready pulse after conversion time
   assign sample        = '{ia: 24'h010000, ib: 24'h020000, ubus: ubus};
   assign enc_inc_pin   = enc[5];
   assign enc_dec_pin   = 1'b0;
   assign adc_ready_pin = cnt > dl && cnt < dl + 16'h4;
   // conversion time latched at the trigger edge
   always @(posedge ref_clk) begin
      prev <= adc_start;
      enc <= enc + 6'h1;
      if (adc_start && !prev)
         {cnt, dl} <= {16'h1, delay};
      else if (cnt != 16'h0 && cnt < dl + 16'h8)
         cnt <= cnt + 16'h1;
   end
endmodule // mdsb_partner
`default_nettype wire

// ### sim/test_motor_drive_sequencer_brake.sv
`include "mdsb_regs.svh"
`default_nettype none
module test_motor_drive_sequencer_brake
   import mdsb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PCYC = 200;
   localparam int SDIV = 2;
   logic            ref_clk, sys_rst, ready, inc, dec, start, brake, upd;
   logic [15:0]     delay;
   logic [23:0]     ubus;
   logic [31:0]     rdata, rdv;
   mdsb_bus_type    bus;
   mdsb_sample_type sample;
   mdsb_dbg_type    dbg;
   mdsb_vec_type    vec;
   int              err_count = 0, checked = 0;
   // device with shortened period, converter and encoder beside it
   mdsb_core #(.PWM_CYC(PCYC), .SPEED_DIV(SDIV)) u_mdsb_core (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .bus(bus), .bus_rdata(rdata), .adc_ready_pin(ready),
      .sample(sample), .enc_inc_pin(inc), .enc_dec_pin(dec), .adc_start(start),
      .brake_out(brake), .dbg(dbg), .pwm_vec(vec), .pwm_update(upd));
   mdsb_partner u_mdsb_partner (.ref_clk(ref_clk), .adc_start(start), .delay(delay),
      .ubus(ubus), .adc_ready_pin(ready), .sample(sample), .enc_inc_pin(inc),
      .enc_dec_pin(dec));
   // 200 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // range compare, exact when both bounds agree
   task automatic cmp(string what, logic [31:0] lo, logic [31:0] hi, logic [31:0] got);
      checked++;
      if ($isunknown(got) || got < lo || got > hi) begin
         err_count++;
         $display("BAD %s expected %h..%h seen %h", what, lo, hi, got);
      end
   endtask
   // one register access, read data kept in rdv
   task automatic acc(bit w, logic [7:0] a, logic [31:0] d);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
      #1 rdv = rdata;
   endtask
   // vector timing, thread counts and speed cadence over ten periods
   task automatic t_period;
      int t0 = 0, up = 0, cur = 0, spd = 0, ov = 0, mst = 0, brk = 0;
      logic pa, ps;
      acc(1'b1, `MDSB_ADR_UPDTIME, 32'h28);
      repeat (PCYC) @(posedge ref_clk) #1;
      {pa, ps} = {start, dbg.speed};
      for (int n = 1; n <= 10 * PCYC; n++) begin
         @(posedge ref_clk) #1;
         if (start && !pa) t0 = n;
         if (upd) up++;
         if (upd && t0 > 0) cmp("vector offset", PCYC - 40, PCYC - 40, n - t0);
         cur += dbg.current;
         mst += dbg.master;
         brk += dbg.brake;
         spd += dbg.speed && !ps;
         ov += $countones(dbg) > 1;
         {pa, ps} = {start, dbg.speed};
      end
      cmp("vector updates", 10, 10, up);
      cmp("current cycles", 30, 30, cur);
      cmp("speed runs", 10 / SDIV, 10 / SDIV, spd);
      cmp("service overlap", 0, 0, ov);
      cmp("master pin cycles", 20, 20, mst);
      cmp("brake pin cycles", 2 * (10 / SDIV), 2 * (10 / SDIV), brk);
      cmp("vector alpha", 32'hFFC000, 32'hFFC000, vec.alpha);
      cmp("vector beta", 32'hFF8000, 32'hFF8000, vec.beta);
   endtask
   // speed from the steady encoder, circle limit and closed loop on
   task automatic t_speed;
      acc(1'b1, `MDSB_ADR_SCALE, 32'h100000);
      acc(1'b1, `MDSB_ADR_CLIM, 32'h010000);
      acc(1'b1, `MDSB_ADR_CTRL, 32'h3);
      repeat (4 * PCYC) @(posedge ref_clk);
      acc(1'b0, `MDSB_ADR_SPEED, 32'h0);
      cmp("speed", 32'h4000, 32'h4000, rdv);
      acc(1'b0, `MDSB_ADR_STATUS, 32'h0);
      cmp("circle flag", 1, 1, rdv[5]);
      cmp("limited alpha", 32'hFFE000, 32'hFFE000, vec.alpha);
      cmp("limited beta", 32'hFFC000, 32'hFFC000, vec.beta);
   endtask
   // settle bus voltage, then check duty and brake on time
   task automatic t_brake(logic [23:0] v, logic [31:0] dlo, dhi, int hlo, hhi);
      int hc = 0;
      ubus <= v;
      repeat (60 * PCYC) @(posedge ref_clk);
      acc(1'b0, `MDSB_ADR_DUTY, 32'h0);
      cmp("brake duty", dlo, dhi, rdv);
      repeat (2 * PCYC) begin
         @(posedge ref_clk) #1;
         hc += brake;
      end
      cmp("brake on cycles", hlo, hhi, hc);
   endtask
   // late samples push one vector update into the next period
   task automatic t_defer;
      int up = 0;
      logic [7:0] d0;
      acc(1'b0, `MDSB_ADR_STATUS, 32'h0);
      d0 = rdv[15:8];
      for (int i = 0; i < 2 * PCYC && !upd; i++) @(posedge ref_clk) #1;
      delay <= 16'h00AA;
      repeat (3 * PCYC + 100) begin
         @(posedge ref_clk) #1;
         up += upd;
      end
      acc(1'b0, `MDSB_ADR_STATUS, 32'h0);
      cmp("deferred updates", d0 + 1, d0 + 1, rdv[15:8]);
      cmp("late vector updates", 2, 2, up);
      delay <= 16'h000A;
   endtask
   // verdict and end of run
   task automatic summarize;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // reset, then scenarios
   initial begin
      {sys_rst, delay, ubus} = {1'b1, 16'h000A, 24'h0};
      bus = '0;
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_period();
      t_brake(24'h500000, 32'h0, 32'h0, 0, 0);
      t_brake(24'h680000, 32'h3FFFE0, 32'h400000, 198, 201);
      t_brake(24'h780000, 32'h800000, 32'h800000, 400, 400);
      t_speed();
      t_defer();
      summarize();
   end
   // cut a hang short
   initial begin
      #400us;
      err_count++;
      summarize();
   end
endmodule // test_motor_drive_sequencer_brake
`default_nettype wire
